// ### src/rrins_defs.svh
// Constants for the return and rotate instruction unit
`ifndef RRINS_DEFS_SVH
`define RRINS_DEFS_SVH
`define RRINS_WORD_W 14
`define RRINS_PC_W 13
`define RRINS_FADDR_W 7
`define RRINS_DATA_W 8
`define RRINS_STACK_DEPTH 8
`define RRINS_PTR_W 3
// Opcode patterns in the 14-bit instruction word
`define RRINS_OP_RETURN 14'h0008
`define RRINS_OP_RETLIT_MASK 14'h3c00
`define RRINS_OP_RETLIT 14'h3400
`define RRINS_OP_ROT_MASK 14'h3f00
`define RRINS_OP_ROTL 14'h0d00
`define RRINS_OP_ROTR 14'h0c00
// Operand field position, reset values and data MSB
`define RRINS_DEST_BIT 7
`define RRINS_RESET_PC 13'h0000
`define RRINS_RESET_BYTE 8'h00
`define RRINS_MSB 7
`endif

// ### src/rrins_pkg.sv
// Types for the return and rotate instruction unit
package rrins_pkg;
    typedef enum logic [2:0] {
        RRINS_OP_NONE,
        RRINS_OP_RET,
        RRINS_OP_RETK,
        RRINS_OP_RL,
        RRINS_OP_RR
    } rrins_op_e;
    typedef enum logic {
        RRINS_ST_FETCH,
        RRINS_ST_FLUSH
    } rrins_state_e;
endpackage : rrins_pkg

// ### src/rrins_decode.sv
// Opcode decoder for the return and rotate instructions
`include "rrins_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module rrins_decode
    import rrins_pkg::*;
(
    // Instruction word
    input wire logic [`RRINS_WORD_W-1:0] word_in,
    // Decoded result
    output var rrins_op_e op_out,
    output logic [`RRINS_FADDR_W-1:0] faddr_out,
    output logic dest_out,
    output logic [`RRINS_DATA_W-1:0] lit_out
);
    // Operand fields sit at fixed positions, so extraction is free
    assign faddr_out = word_in[`RRINS_FADDR_W-1:0];
    assign dest_out = word_in[`RRINS_DEST_BIT];
    assign lit_out = word_in[`RRINS_DATA_W-1:0];

    // Exact match for return, masked match for the rest
    always_comb begin
        op_out = RRINS_OP_NONE;
        if (word_in == `RRINS_OP_RETURN) begin
            op_out = RRINS_OP_RET;
        end else if ((word_in & `RRINS_OP_RETLIT_MASK) == `RRINS_OP_RETLIT) begin
            op_out = RRINS_OP_RETK;
        end else if ((word_in & `RRINS_OP_ROT_MASK) == `RRINS_OP_ROTL) begin
            op_out = RRINS_OP_RL;
        end else if ((word_in & `RRINS_OP_ROT_MASK) == `RRINS_OP_ROTR) begin
            op_out = RRINS_OP_RR;
        end
    end
endmodule : rrins_decode
`default_nettype wire

// ### src/rrins_core.sv
// Return and rotate instruction execution unit
`include "rrins_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module rrins_core
    import rrins_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Instruction fetch
    input wire logic [`RRINS_WORD_W-1:0] instr_in,
    // Stack push from the call logic
    input wire logic push_in,
    input wire logic [`RRINS_PC_W-1:0] push_addr_in,
    // File register read port, combinational by address
    input wire logic [`RRINS_DATA_W-1:0] file_rdata_in,
    output logic [`RRINS_FADDR_W-1:0] file_addr_out,
    // File register write port
    output logic file_we_out,
    output logic [`RRINS_DATA_W-1:0] file_wdata_out,
    // Architectural state
    output logic [`RRINS_PC_W-1:0] program_counter_out,
    output logic [`RRINS_PC_W-1:0] stack_top_out,
    output logic [`RRINS_DATA_W-1:0] w_out,
    output logic carry_out,
    output logic flush_out
);
    rrins_op_e op;
    logic [`RRINS_FADDR_W-1:0] faddr;
    logic dest;
    logic [`RRINS_DATA_W-1:0] lit;

    rrins_decode u_decode (
        .word_in(instr_in),
        .op_out(op),
        .faddr_out(faddr),
        .dest_out(dest),
        .lit_out(lit)
    );

    rrins_state_e state_q, state_d;
    logic [`RRINS_PC_W-1:0] pc_q, pc_d;
    logic [`RRINS_DATA_W-1:0] w_q, w_d;
    logic carry_q, carry_d;
    logic [`RRINS_PTR_W-1:0] sp_q, sp_d;
    logic [`RRINS_PC_W-1:0] stack_q [`RRINS_STACK_DEPTH];
    logic [`RRINS_PC_W-1:0] stack_d [`RRINS_STACK_DEPTH];
    logic [`RRINS_PTR_W-1:0] top_idx;
    logic [`RRINS_DATA_W-1:0] rot_res;
    logic rot_carry;
    logic we_d, we_q;
    logic [`RRINS_DATA_W-1:0] wdata_d, wdata_q;
    logic [`RRINS_FADDR_W-1:0] waddr_d, waddr_q;
    logic pop;
    logic stall;

    // Stack pointer points at the next free slot; top is one below
    assign top_idx = sp_q - 3'h1;
    assign stack_top_out = stack_q[top_idx];
    assign file_addr_out = we_q ? waddr_q : faddr;

    // A rotate left or right after a file write waits one cycle: the shared address
    // port carries the write address then, so the read data would belong to
    // another register; costs one cycle only on back-to-back writes and reads
    assign stall = we_q && (op == RRINS_OP_RL || op == RRINS_OP_RR);

    // Rotate datapath through the carry flag
    // Both directions share one result; the next-state logic picks its target
    always_comb begin
        rot_res = `RRINS_RESET_BYTE;
        rot_carry = carry_q;
        if (op == RRINS_OP_RL) begin
            rot_res = {file_rdata_in[`RRINS_MSB-1:0], carry_q};
            rot_carry = file_rdata_in[`RRINS_MSB];
        end else if (op == RRINS_OP_RR) begin
            rot_res = {carry_q, file_rdata_in[`RRINS_MSB:1]};
            rot_carry = file_rdata_in[0];
        end
    end

    // Next state of the core; the flush cycle is the second cycle of a return
    always_comb begin
        state_d = RRINS_ST_FETCH;
        pc_d = pc_q;
        w_d = w_q;
        carry_d = carry_q;
        we_d = 1'b0;
        wdata_d = wdata_q;
        waddr_d = waddr_q;
        pop = 1'b0;
        if (state_q == RRINS_ST_FLUSH) begin
            // Fetched word is discarded while the new target is fetched
            state_d = RRINS_ST_FETCH;
            pc_d = pc_q + 13'h0001;
        end else if (stall) begin
            // Program counter holds, so fetch presents the same rotate again
            pc_d = pc_q;
        end else begin
            case (op)
                RRINS_OP_RET: begin
                    pop = 1'b1;
                    pc_d = stack_q[top_idx];
                    state_d = RRINS_ST_FLUSH;
                end
                RRINS_OP_RETK: begin
                    // Literal and target land together, at the edge that enters the flush cycle
                    w_d = lit;
                    pop = 1'b1;
                    pc_d = stack_q[top_idx];
                    state_d = RRINS_ST_FLUSH;
                end
                RRINS_OP_RL,
                RRINS_OP_RR: begin
                    // Carry is the only flag touched; a file write goes out registered
                    carry_d = rot_carry;
                    pc_d = pc_q + 13'h0001;
                    if (dest) begin
                        we_d = 1'b1;
                        wdata_d = rot_res;
                        waddr_d = faddr;
                    end else begin
                        w_d = rot_res;
                    end
                end
                default: begin
                    pc_d = pc_q + 13'h0001;
                end
            endcase
        end
    end

    // Circular hardware stack; overflow wraps and overwrites the oldest entry
    always_comb begin
        sp_d = sp_q;
        for (int i = 0; i < `RRINS_STACK_DEPTH; i++) begin
            stack_d[i] = stack_q[i];
        end
        // A pop wins over a push in the same cycle, so a call cannot corrupt a return
        if (pop) begin
            sp_d = top_idx;
        end else if (push_in && state_q == RRINS_ST_FETCH) begin
            stack_d[sp_q] = push_addr_in;
            sp_d = sp_q + 3'h1;
        end
    end

    // State registers
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state_q <= RRINS_ST_FETCH;
            pc_q <= `RRINS_RESET_PC;
            w_q <= `RRINS_RESET_BYTE;
            carry_q <= 1'b0;
            sp_q <= '0;
            we_q <= 1'b0;
            wdata_q <= `RRINS_RESET_BYTE;
            waddr_q <= '0;
        end else begin
            state_q <= state_d;
            pc_q <= pc_d;
            w_q <= w_d;
            carry_q <= carry_d;
            sp_q <= sp_d;
            we_q <= we_d;
            wdata_q <= wdata_d;
            waddr_q <= waddr_d;
        end
    end

    // Stack storage, one generate entry per slot
    for (genvar g = 0; g < `RRINS_STACK_DEPTH; g++) begin : g_stack
        always_ff @(posedge clk_in) begin
            if (sys_rst_in) begin
                stack_q[g] <= `RRINS_RESET_PC;
            end else begin
                stack_q[g] <= stack_d[g];
            end
        end
    end

    // Outputs; the file write lands one cycle after the rotate is taken
    assign program_counter_out = pc_q;
    assign w_out = w_q;
    assign carry_out = carry_q;
    assign file_we_out = we_q;
    assign file_wdata_out = wdata_q;
    assign flush_out = (state_q == RRINS_ST_FLUSH);

    // Return checks; both kinds pop and reload the program counter, then
    // spend one flush cycle in which the fetched word is thrown away
    a_retk_loads_w: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_q == RRINS_ST_FETCH && op == RRINS_OP_RETK) |=> (w_q == $past(lit)))
        else $error("literal return did not load W");
    a_retk_no_write: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_q == RRINS_ST_FETCH && op == RRINS_OP_RETK) |=> !file_we_out)
        else $error("literal return wrote the file");
    a_retk_pc_top: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_q == RRINS_ST_FETCH && op == RRINS_OP_RETK) |=> (pc_q == $past(stack_top_out)))
        else $error("literal return did not load PC from stack top");
    a_retk_pops: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_q == RRINS_ST_FETCH && op == RRINS_OP_RETK) |=>
        (sp_q == $past(sp_q) - 3'h1))
        else $error("literal return did not pop");
    a_retk_two_cyc: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_q == RRINS_ST_FETCH && op == RRINS_OP_RETK) |=> flush_out ##1 !flush_out)
        else $error("literal return not two cycles");
    a_retk_no_flag: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_q == RRINS_ST_FETCH && op == RRINS_OP_RETK) |=> $stable(carry_q))
        else $error("literal return changed carry");
    a_ret_pops: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_q == RRINS_ST_FETCH && op == RRINS_OP_RET) |=> (sp_q == $past(sp_q) - 3'h1) && $stable(carry_q))
        else $error("return did not pop cleanly");
    a_ret_keeps_w: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_q == RRINS_ST_FETCH && op == RRINS_OP_RET) |=> $stable(w_q) && !file_we_out)
        else $error("return touched W or the file");
    a_ret_no_push: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_q == RRINS_ST_FETCH && (op == RRINS_OP_RET || op == RRINS_OP_RETK) && push_in) |=>
        (sp_q == $past(sp_q) - 3'h1))
        else $error("push taken in the first cycle of a return");
    a_ret_pc_load: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_q == RRINS_ST_FETCH && op == RRINS_OP_RET) |=> (pc_q == $past(stack_top_out)) && flush_out)
        else $error("return did not load PC");
    a_ret_two_cyc: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_q == RRINS_ST_FETCH && op == RRINS_OP_RET) |=> flush_out ##1 !flush_out)
        else $error("return not two cycles");

    // Stack check; a plain push must become the new top for a later return
    a_push_lands: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_q == RRINS_ST_FETCH && op == RRINS_OP_NONE && push_in) |=>
        (stack_top_out == $past(push_addr_in)))
        else $error("pushed address is not the stack top");

    // Rotate checks; a stalled rotate is checked in the cycle in which it
    // finally executes, so every antecedent leaves the stall cycle out
    a_rl_result: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_q == RRINS_ST_FETCH && op == RRINS_OP_RL && !dest && !stall) |=>
        ({carry_q, w_q} == {$past(file_rdata_in), $past(carry_q)}))
        else $error("rotate left result wrong");
    a_rl_dest_file: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_q == RRINS_ST_FETCH && op == RRINS_OP_RL && dest && !stall) |=>
        file_we_out && $stable(w_q))
        else $error("rotate left did not write file");
    a_rl_file_data: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_q == RRINS_ST_FETCH && op == RRINS_OP_RL && dest && !stall) |=>
        (file_wdata_out == {$past(file_rdata_in[`RRINS_MSB-1:0]), $past(carry_q)}))
        else $error("rotate left file data wrong");
    a_rr_result: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_q == RRINS_ST_FETCH && op == RRINS_OP_RR && !dest && !stall) |=>
        ({w_q, carry_q} == {$past(carry_q), $past(file_rdata_in)}))
        else $error("rotate right result wrong");
    a_rr_dest_file: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_q == RRINS_ST_FETCH && op == RRINS_OP_RR && dest && !stall) |=>
        file_we_out && file_wdata_out == {$past(carry_q), $past(file_rdata_in[7:1])})
        else $error("rotate right file write wrong");
    a_rr_keeps_w: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_q == RRINS_ST_FETCH && op == RRINS_OP_RR && dest && !stall) |=> $stable(w_q))
        else $error("rotate right to file changed W");
    a_rot_addr: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_q == RRINS_ST_FETCH && (op == RRINS_OP_RL || op == RRINS_OP_RR) && dest && !stall) |=>
        (file_addr_out == $past(instr_in[6:0])))
        else $error("rotate write address wrong");
    a_rot_w_only: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_q == RRINS_ST_FETCH && (op == RRINS_OP_RL || op == RRINS_OP_RR) && !dest && !stall) |=>
        !file_we_out)
        else $error("rotate to W wrote the file");
    a_rot_pc_step: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_q == RRINS_ST_FETCH && (op == RRINS_OP_RL || op == RRINS_OP_RR) && !stall) |=>
        (pc_q == $past(pc_q) + 13'h0001))
        else $error("rotate did not step the program counter");
    a_rl_carry_in: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_q == RRINS_ST_FETCH && op == RRINS_OP_RL && dest && !stall) |=>
        file_wdata_out[0] == $past(carry_q) && carry_q == $past(file_rdata_in[7]))
        else $error("rotate left carry path wrong");
    a_rr_carry_in: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_q == RRINS_ST_FETCH && op == RRINS_OP_RR && dest && !stall) |=>
        file_wdata_out[7] == $past(carry_q) && carry_q == $past(file_rdata_in[0]))
        else $error("rotate right carry path wrong");

    // Stall and flush checks; neither cycle may change W, carry or the program counter, or
    // start a file write, except the program counter step that the flush makes
    a_rot_stall: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_q == RRINS_ST_FETCH && stall) |=>
        $stable(pc_q) && $stable(carry_q) && $stable(w_q) && !file_we_out)
        else $error("rotate ran while the write held the address port");
    a_write_pulse: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        file_we_out |=> !file_we_out)
        else $error("file write longer than one cycle");
    a_flush_idle: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_q == RRINS_ST_FLUSH) |=> $stable(w_q) && $stable(carry_q) && !file_we_out && !flush_out)
        else $error("flush cycle executed an instruction");
endmodule : rrins_core
`default_nettype wire

// ### tb/return_and_rotate_instructions_test.sv
// Self-checking bench for the return and rotate instruction unit
`include "rrins_defs.svh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin err_total++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, got, exp); end end
module return_and_rotate_instructions_test;
    // One rotate case: instruction, file data read, expected result and carry
    typedef struct packed {
        logic [13:0] instr;
        logic [7:0] rd;
        logic [7:0] res;
        logic c;
    } rrins_row_s;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [13:0] instr;
    logic push;
    logic [12:0] push_addr;
    logic [7:0] rdata;
    wire logic [6:0] faddr;
    wire logic we;
    wire logic [7:0] wdata;
    wire logic [12:0] pc;
    wire logic [12:0] top;
    wire logic [7:0] w;
    wire logic carry;
    wire logic flush;
    int err_total = 0;
    int comparisons = 0;
    logic [7:0] w_exp;
    // Carry runs on from row to row, so each row's result depends on the one before
    rrins_row_s rows [7] = '{'{14'h0d85, 8'h81, 8'h02, 1'b1}, '{14'h0d7f, 8'h40, 8'h81, 1'b0},
        '{14'h0c00, 8'h01, 8'h00, 1'b1}, '{14'h0cff, 8'h80, 8'hc0, 1'b0}, '{14'h0d2a, 8'hff, 8'hfe, 1'b1},
        '{14'h0c91, 8'h00, 8'h80, 1'b0}, '{14'h0d01, 8'h80, 8'h00, 1'b1}};

    // Clock at 40 MHz
    always #12.5 clk_in = ~clk_in;

    rrins_core DUT (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .instr_in(instr), .push_in(push),
        .push_addr_in(push_addr), .file_rdata_in(rdata), .file_addr_out(faddr), .file_we_out(we),
        .file_wdata_out(wdata), .program_counter_out(pc), .stack_top_out(top), .w_out(w),
        .carry_out(carry), .flush_out(flush)
    );

    // Inputs always change 1 ns after the edge, well clear of sampling
    task drive(input logic [13:0] i, input logic p, input logic [12:0] a);
        @(posedge clk_in);
        #1;
        instr = i;
        push = p;
        push_addr = a;
    endtask : drive

    // Prints counts and verdict, then stops the run
    task summarize;
        $display("Counts: %0d compared, %0d mismatched", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize

    // Watchdog so a stuck run still reaches the verdict
    initial begin
        repeat (2000) @(posedge clk_in);
        err_total++;
        $display("Watchdog expired");
        summarize();
    end

    // Main sequence
    initial begin
        instr = 14'h0000;
        push = 1'b0;
        push_addr = 13'h0000;
        rdata = 8'h00;
        w_exp = 8'h00;
        repeat (2) @(posedge clk_in);
        #1;
        sys_rst_in = 1'b0;
        `CHK(pc, 13'h0000)
        `CHK({w, carry, flush, we}, 11'h000)
        $display("Reset test done");
        // Rotate table; a NOP follows each so the write cycle stands alone
        foreach (rows[i]) begin
            drive(rows[i].instr, 1'b0, 13'h0000);
            rdata = rows[i].rd;
            #1;
            `CHK(we, 1'b0)
            `CHK(faddr, rows[i].instr[6:0])
            drive(14'h0000, 1'b0, 13'h0000);
            if (!rows[i].instr[7])
                w_exp = rows[i].res;
            `CHK(w, w_exp)
            `CHK(carry, rows[i].c)
            `CHK(flush, 1'b0)
            `CHK(we, rows[i].instr[7])
            if (rows[i].instr[7]) begin
                `CHK(wdata, rows[i].res)
                `CHK(faddr, rows[i].instr[6:0])
            end
        end
        $display("Rotate table done");
        // Three pushes, then literal return with a rotate hidden in its flush cycle
        drive(14'h0000, 1'b1, 13'h0123);
        drive(14'h0000, 1'b1, 13'h1abc);
        drive(14'h0000, 1'b1, 13'h0f0f);
        drive(14'h0000, 1'b0, 13'h0000);
        `CHK(top, 13'h0f0f)
        rdata = 8'h80;
        drive(14'h34ff, 1'b0, 13'h0000);
        drive(14'h0d00, 1'b1, 13'h1111);
        `CHK(w, 8'hff)
        `CHK(pc, 13'h0f0f)
        `CHK(flush, 1'b1)
        `CHK(carry, 1'b1)
        drive(14'h0008, 1'b1, 13'h1555);
        `CHK(pc, 13'h0f10)
        `CHK(flush, 1'b0)
        `CHK({w, carry}, 9'h1ff)
        `CHK(top, 13'h1abc)
        drive(14'h0000, 1'b0, 13'h0000);
        `CHK(pc, 13'h1abc)
        `CHK(flush, 1'b1)
        `CHK({w, carry}, 9'h1ff)
        drive(14'h3700, 1'b0, 13'h0000);
        `CHK(flush, 1'b0)
        `CHK(pc, 13'h1abd)
        `CHK(top, 13'h0123)
        drive(14'h0000, 1'b0, 13'h0000);
        `CHK(w, 8'h00)
        `CHK(pc, 13'h0123)
        `CHK(carry, 1'b1)
        $display("Return test done");
        // Rotate to file, then a rotate of the same register straight after it
        drive(14'h0d85, 1'b0, 13'h0000);
        rdata = 8'h81;
        drive(14'h0c05, 1'b0, 13'h0000);
        `CHK(we, 1'b1)
        `CHK(wdata, 8'h03)
        `CHK(faddr, 7'h05)
        // Word is held while the write owns the address port; file now holds the result
        drive(14'h0c05, 1'b0, 13'h0000);
        rdata = 8'h03;
        `CHK(pc, 13'h0125)
        `CHK(we, 1'b0)
        `CHK(faddr, 7'h05)
        `CHK(carry, 1'b1)
        drive(14'h0000, 1'b0, 13'h0000);
        `CHK(w, 8'h81)
        `CHK(pc, 13'h0126)
        $display("Stall test done");
        // Reset in mid-run clears the stack and state
        sys_rst_in = 1'b1;
        drive(14'h0000, 1'b0, 13'h0000);
        sys_rst_in = 1'b0;
        `CHK({pc, top}, 26'h0000000)
        `CHK({w, carry, flush, we}, 11'h000)
        $display("Second reset test done");
        summarize();
    end
endmodule : return_and_rotate_instructions_test
`default_nettype wire
